/* pkg/gpm_params.svh */
`ifndef GPM_PARAMS_SVH
`define GPM_PARAMS_SVH

// ----------------------------------------
// Register indexes, groups in the word index high nibble; byte address is four times the word index
// ----------------------------------------
`define GPM_IDX_OUT 4'h0
`define GPM_IDX_IN 4'h1
`define GPM_IDX_DIR 4'h2
`define GPM_IDX_FUNC 4'h3
`define GPM_IDX_CAUSE 8'h40

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define GPM_RST_OUT 8'h00
`define GPM_RST_DIR 8'h00
`define GPM_RST_FUNC 8'h00
`define GPM_RST_FUNC_ALL 8'hFF
`define GPM_RST_FUNC2 8'h7F
`define GPM_RST_CAUSE 2'h1
`define GPM_CAUSE_EXT 0
`define GPM_CAUSE_WDT 1

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define GPM_RESP_OKAY 2'h0
`define GPM_RESP_SLVERR 2'h2

`endif

/* pkg/gpm_pkg.sv */
package gpm_pkg;

  // Register groups reached over the bus
  typedef enum {
    GPM_K_OUT,
    GPM_K_IN,
    GPM_K_DIR,
    GPM_K_FUNC,
    GPM_K_CAUSE,
    GPM_K_NONE
  } gpm_kind_t;

endpackage

/* core/gpm_pin_cell.sv */
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_cell #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Port control from the registers
  input wire logic [W-1:0] func_sel,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] out_data,
  // Secondary function owner
  input wire logic [W-1:0] alt_out,
  input wire logic [W-1:0] alt_oe,
  // Pad side
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] readback
);

  logic [W-1:0] oe_next;
  logic [W-1:0] out_next;

  // ----------------------------------------
  // Pin steering
  // ----------------------------------------
  // Peripheral owns the pin when selected, else the port registers
  assign oe_next = (func_sel & alt_oe) | (~func_sel & dir);
  assign out_next = (func_sel & alt_out) | (~func_sel & out_data);

  // Registered pad drive keeps glitches off the pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe <= '0;
      pin_out <= '0;
    end else begin
      pin_oe <= oe_next;
      pin_out <= out_next;
    end
  end

  // Driven level for outputs, pad level for inputs
  assign readback = (pin_oe & pin_out) | (~pin_oe & pin_in);

endmodule
`default_nettype wire

/* core/gpm_port_mux.sv */
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "gpm_params.svh"
module gpm_port_mux
  import gpm_pkg::*;
#(
  parameter int NPORT = 9,
  parameter int PORT_W = 8,
  parameter int AW = 12
) (
  // Clock and external reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reset cause and strap pins
  input wire logic watchdog_overflow_reset,
  input wire logic address_bus_strap_pin_n,
  input wire logic data_width_strap_pin,
  input wire logic debug_strap_pin,
  // AXI4-Lite write channels
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pads, port p bit b at index 8p+b
  input wire logic [NPORT*PORT_W-1:0] pin_in,
  output logic [NPORT*PORT_W-1:0] pin_out,
  output logic [NPORT*PORT_W-1:0] pin_oe,
  // Secondary function owners
  input wire logic [NPORT*PORT_W-1:0] alt_out,
  input wire logic [NPORT*PORT_W-1:0] alt_oe,
  output logic [NPORT*PORT_W-1:0] alt_in
);

  localparam int NB = NPORT * PORT_W;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Word index high nibble picks the group, low nibble the port
  function automatic gpm_kind_t dec_kind(input logic [AW-1:0] a);
    gpm_kind_t k;
    k = GPM_K_NONE;
    if (a[1:0] == 2'h0 && a[AW-1:10] == '0) begin
      if (a[9:2] == `GPM_IDX_CAUSE)
        k = GPM_K_CAUSE;
      else if (32'(a[5:2]) < NPORT) begin
        case (a[9:6])
          `GPM_IDX_OUT: k = GPM_K_OUT;
          `GPM_IDX_IN: k = GPM_K_IN;
          `GPM_IDX_DIR: k = GPM_K_DIR;
          `GPM_IDX_FUNC: k = GPM_K_FUNC;
          default: k = GPM_K_NONE;
        endcase
      end
    end
    return k;
  endfunction

  // Ports six and eight have no writable selection
  function automatic logic func_writable(input logic [3:0] p);
    return (p != 4'h6) && (p != 4'h8);
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [NPORT-1:0][PORT_W-1:0] odat_reg, odat_next;
  logic [NPORT-1:0][PORT_W-1:0] dir_reg, dir_next;
  logic [NPORT-1:0][PORT_W-1:0] fsel_reg, fsel_next, fsel_rst;
  logic [NPORT-1:0][PORT_W-1:0] pi_val;
  logic [1:0] cause_reg, cause_next;
  logic [NB-1:0] alt_in_reg;

  // Bus engine state
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic [AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  // ----------------------------------------
  // Write channel handshakes
  // ----------------------------------------
  logic aw_fire, w_fire, b_fire, aw_have, w_have, wr_en, wr_lane;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [7:0] wr_byte;
  logic [3:0] wr_port;
  gpm_kind_t wr_kind;

  // Address and data may land in either order
  assign aw_fire = s_axi_awvalid & awready_reg;
  assign w_fire = s_axi_wvalid & wready_reg;
  assign b_fire = bvalid_reg & s_axi_bready;
  assign aw_have = aw_fire | (~awready_reg & ~bvalid_reg);
  assign w_have = w_fire | (~wready_reg & ~bvalid_reg);
  assign wr_en = aw_have & w_have & ~bvalid_reg;
  assign wr_addr = aw_fire ? s_axi_awaddr : awaddr_reg;
  assign wr_data = w_fire ? s_axi_wdata : wdata_reg;
  assign wr_lane = wr_en & (w_fire ? s_axi_wstrb[0] : wstrb0_reg);
  assign wr_byte = wr_data[7:0];
  assign wr_port = wr_addr[5:2];
  assign wr_kind = dec_kind(wr_addr);

  // Ready drops once taken and returns after the response
  assign awready_next = aw_fire ? 1'b0 : (b_fire ? 1'b1 : awready_reg);
  assign wready_next = w_fire ? 1'b0 : (b_fire ? 1'b1 : wready_reg);
  assign bvalid_next = wr_en ? 1'b1 : (b_fire ? 1'b0 : bvalid_reg);
  assign bresp_next = !wr_en ? bresp_reg :
    (wr_kind == GPM_K_NONE) ? `GPM_RESP_SLVERR : `GPM_RESP_OKAY;

  // ----------------------------------------
  // Register next values and strap reset values
  // ----------------------------------------
  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      logic hit;
      assign hit = wr_lane && (wr_port == 4'(p));
      assign odat_next[p] = (hit && wr_kind == GPM_K_OUT) ? wr_byte
                                                           : odat_reg[p];
      assign dir_next[p] = (hit && wr_kind == GPM_K_DIR) ? wr_byte
                                                          : dir_reg[p];
      // Only software rewrites a selection, a watchdog reset does not
      assign fsel_next[p] = (hit && wr_kind == GPM_K_FUNC &&
                             func_writable(4'(p))) ? wr_byte
                                                   : fsel_reg[p];
      // Per-port pin cell, every bit steered on its own
      gpm_pin_cell #(.W(PORT_W)) u_cell (
        .aclk(aclk),
        .aresetn(aresetn),
        .func_sel(fsel_reg[p]),
        .dir(dir_reg[p]),
        .out_data(odat_reg[p]),
        .alt_out(alt_out[p*PORT_W +: PORT_W]),
        .alt_oe(alt_oe[p*PORT_W +: PORT_W]),
        .pin_in(pin_in[p*PORT_W +: PORT_W]),
        .pin_out(pin_out[p*PORT_W +: PORT_W]),
        .pin_oe(pin_oe[p*PORT_W +: PORT_W]),
        .readback(pi_val[p])
      );
      // Selection loaded at external reset
      if (p == 0) begin : g_rst0
        assign fsel_rst[p] = address_bus_strap_pin_n ? `GPM_RST_FUNC
                                                    : `GPM_RST_FUNC_ALL;
      end else if (p == 1) begin : g_rst1
        assign fsel_rst[p] = data_width_strap_pin ? `GPM_RST_FUNC_ALL
                                                 : `GPM_RST_FUNC;
      end else if (p == 2) begin : g_rst2
        assign fsel_rst[p] = `GPM_RST_FUNC2;
      end else if (p == 8) begin : g_rst8
        assign fsel_rst[p] = debug_strap_pin ? `GPM_RST_FUNC_ALL
                                            : `GPM_RST_FUNC;
      end else begin : g_rstn
        assign fsel_rst[p] = `GPM_RST_FUNC;
      end
    end
  endgenerate

  // Watchdog cause is sticky; its set wins over a clear
  assign cause_next = (cause_reg & ~((wr_lane && wr_kind == GPM_K_CAUSE)
                        ? wr_byte[1:0] : 2'h0))
                      | {watchdog_overflow_reset, 1'b0};

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic ar_fire, r_fire;
  logic [3:0] rd_port;
  logic [7:0] rd_byte;
  gpm_kind_t rd_kind;

  assign ar_fire = s_axi_arvalid & arready_reg;
  assign r_fire = rvalid_reg & s_axi_rready;
  assign rd_kind = dec_kind(s_axi_araddr);
  assign rd_port = s_axi_araddr[5:2];
  // Input group returns pin or driven level per bit
  assign rd_byte =
    (rd_kind == GPM_K_OUT) ? odat_reg[rd_port] :
    (rd_kind == GPM_K_IN) ? pi_val[rd_port] :
    (rd_kind == GPM_K_DIR) ? dir_reg[rd_port] :
    (rd_kind == GPM_K_FUNC) ? fsel_reg[rd_port] :
    (rd_kind == GPM_K_CAUSE) ? {6'h00, cause_reg} : 8'h00;
  assign arready_next = ar_fire ? 1'b0 : (r_fire ? 1'b1 : arready_reg);
  assign rvalid_next = ar_fire ? 1'b1 : (r_fire ? 1'b0 : rvalid_reg);
  assign rdata_next = ar_fire ? {24'h000000, rd_byte} : rdata_reg;
  assign rresp_next = !ar_fire ? rresp_reg :
    (rd_kind == GPM_K_NONE) ? `GPM_RESP_SLVERR : `GPM_RESP_OKAY;

  // ----------------------------------------
  // Port and cause registers
  // ----------------------------------------
  // Straps are caught while external reset is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      odat_reg <= {NPORT{`GPM_RST_OUT}};
      dir_reg <= {NPORT{`GPM_RST_DIR}};
      fsel_reg <= fsel_rst;
      cause_reg <= `GPM_RST_CAUSE;
    end else begin
      odat_reg <= odat_next;
      dir_reg <= dir_next;
      fsel_reg <= fsel_next;
      cause_reg <= cause_next;
    end
  end

  // Pad levels handed on to peripherals, one stage of delay
  always_ff @(posedge aclk) begin
    if (!aresetn)
      alt_in_reg <= '0;
    else
      alt_in_reg <= pin_in;
  end

  // ----------------------------------------
  // Bus engine registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `GPM_RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `GPM_RESP_OKAY;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Payload holders need no reset, they are read only when held
  always_ff @(posedge aclk) begin
    if (aw_fire)
      awaddr_reg <= s_axi_awaddr;
    if (w_fire) begin
      wdata_reg <= s_axi_wdata;
      wstrb0_reg <= s_axi_wstrb[0];
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign alt_in = alt_in_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_input_no_drive: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aresetn |=> ((pin_oe & ~$past(fsel_reg) & ~$past(dir_reg)) == '0))
    else $error("port input pin is driven");

  chk_alt_owns_dir: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aresetn |=> (((pin_oe ^ $past(alt_oe)) & $past(fsel_reg)) == '0))
    else $error("secondary pin ignores peripheral enable");

  chk_dir_sets_out: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aresetn |=> (((pin_oe ^ $past(dir_reg)) & ~$past(fsel_reg)) == '0))
    else $error("port direction not applied");

  chk_out_level: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aresetn |=> ((pin_oe & ~$past(fsel_reg) &
                  (pin_out ^ $past(odat_reg))) == '0))
    else $error("port output level wrong");

  chk_plain_inputs: assert property (
    @(posedge aclk) !aresetn |=> (fsel_reg[7:3] == '0 && !fsel_reg[2][7]))
    else $error("plain ports not plain after reset");

  chk_mem_strobes: assert property (
    @(posedge aclk) !aresetn |=> (fsel_reg[2][6:0] == 7'h7F))
    else $error("memory strobes not selected after reset");

  chk_addr_strap: assert property (
    @(posedge aclk) !aresetn |=>
      (fsel_reg[0] == {8{!$past(address_bus_strap_pin_n)}}))
    else $error("address strap not applied");

  chk_width_strap: assert property (
    @(posedge aclk) !aresetn |=>
      (fsel_reg[1] == {8{$past(data_width_strap_pin)}}))
    else $error("data width strap not applied");

  chk_debug_strap: assert property (
    @(posedge aclk) !aresetn |=>
      (fsel_reg[8] == {8{$past(debug_strap_pin)}}))
    else $error("debug strap not applied");

  chk_wdt_keeps_func: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (watchdog_overflow_reset && !wr_lane) |=> $stable(fsel_reg))
    else $error("watchdog reset changed pin functions");

  chk_dir_cleared: assert property (
    @(posedge aclk) !aresetn |=> (dir_reg == '0 && pin_oe == '0))
    else $error("direction not cleared by reset");

endmodule
`default_nettype wire

/* dv/gpm_pad_model.sv */
`timescale 1ns/1ns
`default_nettype none
module gpm_pad_model #(
  parameter int NB = 72
) (
  // Clock
  input wire logic aclk,
  // Device pad side
  input wire logic [NB-1:0] pin_out,
  input wire logic [NB-1:0] pin_oe,
  // Far-side drivers
  input wire logic [NB-1:0] ext_val,
  input wire logic [NB-1:0] ext_oe,
  output logic [NB-1:0] pin_in
);
  logic [NB-1:0] float_reg = '0;
  // Undriven lines wander so a stale level never passes for a real one
  always @(posedge aclk) begin
    float_reg <= ~float_reg;
  end
  // Device drive wins, then the far side, else the wandering level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) |
                  (~pin_oe & ~ext_oe & float_reg);
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "gpm_params.svh"
module testbench;
  import gpm_pkg::*;
  typedef struct packed {
    logic wr;
    logic [11:0] a;
    logic [7:0] d;
  } gpm_row_t;
  logic aclk, aresetn, wdg, ea_n, dw, dbg;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [71:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in;
  logic [71:0] ext_val, ext_oe;
  logic [7:0] rd_d;
  int err_total = 0;
  int comparisons = 0;
  gpm_row_t rows [0:12];
  logic [7:0] sel_exp [0:8];

  gpm_port_mux DUT (.aclk(aclk), .aresetn(aresetn),
    .watchdog_overflow_reset(wdg), .address_bus_strap_pin_n(ea_n),
    .data_width_strap_pin(dw), .debug_strap_pin(dbg),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in));
  gpm_pad_model #(.NB(72)) pads (.aclk(aclk), .pin_out(pin_out),
    .pin_oe(pin_oe), .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #40000;
    err_total++;
    give_verdict;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Full pad width, so wide compares are never cut short
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Starts one edge late so bready/rready never toggle twice in a step
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Wait as long as the slave needs; only the watchdog ends a hang
    while (!got) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        rsp = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  task automatic axi_rd(input logic [11:0] a);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        rsp = rresp;
        rd_d = rdata[7:0];
        rready <= 1'b0;
        check(rdata[31:8], 24'h000000);
      end
    end
  endtask
  task automatic ext_reset;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {wdg, awaddr, araddr, awvalid, wvalid, bready} = '0;
    {arvalid, rready, wdata, alt_out, alt_oe} = '0;
    wstrb = 4'hF;
    {ea_n, dw, dbg} = 3'b011;
    ext_val = {9{8'hF0}};
    ext_oe = '1;
    sel_exp = '{8'hFF, 8'hFF, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                8'hFF};
    // Last two rows: a write to the input group must change nothing
    rows = '{'{1'b1, 12'h08C, 8'hA5}, '{1'b1, 12'h00C, 8'h3C},
             '{1'b0, 12'h08C, 8'hA5}, '{1'b0, 12'h00C, 8'h3C},
             '{1'b0, 12'h04C, 8'h74}, '{1'b1, 12'h088, 8'hFF},
             '{1'b1, 12'h008, 8'h80}, '{1'b1, 12'h0C0, 8'h0F},
             '{1'b0, 12'h0C0, 8'h0F}, '{1'b1, 12'h0D8, 8'h5A},
             '{1'b0, 12'h0D8, 8'h00}, '{1'b1, 12'h04C, 8'hFF},
             '{1'b0, 12'h04C, 8'h74}};
    aresetn = 1'b0;
    ext_reset;
    check(pin_oe, 72'h0);
    alt_oe[23:16] <= 8'h55;
    alt_out[23:16] <= 8'h33;
    // Reset state of direction and function registers
    for (int p = 0; p < 9; p++) begin
      axi_rd(12'h080 + 12'(4 * p));
      check(rd_d, 8'h00);
      axi_rd(12'h0C0 + 12'(4 * p));
      check(rd_d, sel_exp[p]);
    end
    // Ordinary register traffic
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_wr(rows[i].a, rows[i].d);
        check(rsp, `GPM_RESP_OKAY);
      end else begin
        axi_rd(rows[i].a);
        check(rd_d, rows[i].d);
      end
    end
    repeat (2) @(posedge aclk);
    check(pin_oe[31:24], 8'hA5);
    check(pin_out[31:24] & pin_oe[31:24], 8'h24);
    check(pin_oe[23:16], 8'hD5);
    check(pin_out[23:16] & pin_oe[23:16], 8'h91);
    // Peripherals see the pad level one cycle late
    check(alt_in[31:24], 8'h74);
    // Straps moving after reset must not touch the selections
    {ea_n, dw, dbg} <= 3'b100;
    axi_rd(12'h0C4);
    check(rd_d, 8'hFF);
    axi_rd(12'h0E0);
    check(rd_d, 8'hFF);
    // Watchdog reset must keep every selection and direction
    wdg <= 1'b1;
    @(posedge aclk);
    wdg <= 1'b0;
    repeat (2) @(posedge aclk);
    check(pin_oe[31:24], 8'hA5);
    axi_rd(12'h0C0);
    check(rd_d, 8'h0F);
    axi_rd(12'h08C);
    check(rd_d, 8'hA5);
    axi_rd(12'h100);
    check(rd_d, 8'h03);
    // Writing ones clears the cause bits
    axi_wr(12'h100, 8'h03);
    check(rsp, `GPM_RESP_OKAY);
    axi_rd(12'h100);
    check(rd_d, 8'h00);
    // Unmapped places answer with an error
    axi_rd(12'h104);
    check(rsp, `GPM_RESP_SLVERR);
    check(rd_d, 8'h00);
    axi_wr(12'h120, 8'hFF);
    check(rsp, `GPM_RESP_SLVERR);
    // Second external reset with the opposite straps
    {ea_n, dw, dbg} <= 3'b100;
    ext_reset;
    check(pin_oe[71:24], 48'h0);
    check(pin_oe[15:0], 16'h0);
    axi_rd(12'h0C0);
    check(rd_d, 8'h00);
    axi_rd(12'h0C4);
    check(rd_d, 8'h00);
    axi_rd(12'h0E0);
    check(rd_d, 8'h00);
    axi_rd(12'h0C8);
    check(rd_d, 8'h7F);
    axi_rd(12'h08C);
    check(rd_d, 8'h00);
    axi_rd(12'h100);
    check(rd_d, 8'h01);
    give_verdict;
  end
endmodule
`default_nettype wire
